/* File: hw/exp_seq_defines.svh */
// Notes on behaviour
// - in multiplexed mode the address latch pulse stays high for 1 to 4 cycles, set by the address phase setting.
// - in multiplexed mode the address is already on the shared lines when the latch pulse rises.
// - after the latch pulse falls the address stays on the lines for exactly one more cycle.
// - in multiplexed mode chip select asserts exactly one cycle after the latch pulse falls.
// - in simplex mode the address is driven 1 to 4 cycles (address phase setting) before chip select.
// - on writes data is driven 1 to 4 cycles (data setup setting) before the write strobe falls.
// - the write strobe stays low 1 to 16 cycles (strobe setting) with write data valid throughout.
// - the strobe setting times read and write strobes alike.
// - after the write strobe rises data stays valid 1 to 4 cycles (hold setting).
// - during hold, chip select, address and write data stay stable for the hold count.
// - successive accesses are separated by a recovery gap of 1 to 16 cycles (recovery setting).
// - every phase count is measured in clock periods of the bus clock.
// - in simplex mode the latch pulse is never used; address and data use separate lines.
`ifndef EXP_SEQ_DEFINES_SVH
`define EXP_SEQ_DEFINES_SVH
`define EXP_ADDR_W     16
`define EXP_DATA_W     16
`define EXP_SHORT_W    2
`define EXP_LONG_W     4
`define EXP_CNT_W      4
`define EXP_LATCH_HOLD 4'h0
`endif

/* File: hw/exp_seq_pkg.sv */
package exp_seq_pkg;
  // ==========================================================
  // phase states, one-hot
  typedef enum logic [7:0] {
    ST_IDLE   = 8'b0000_0001,
    ST_LATCH  = 8'b0000_0010,
    ST_LHOLD  = 8'b0000_0100,
    ST_ADDR   = 8'b0000_1000,
    ST_SETUP  = 8'b0001_0000,
    ST_STROBE = 8'b0010_0000,
    ST_HOLD   = 8'b0100_0000,
    ST_RECOV  = 8'b1000_0000
  } phase_t;
endpackage : exp_seq_pkg

/* File: hw/phase_timer.sv */
`timescale 1ns/1ns
`include "exp_seq_defines.svh"
module phase_timer (
  input  wire logic                  clk_sys_i,
  input  wire logic                  rstn_i,
  input  wire logic                  load_i,
  input  wire logic [`EXP_CNT_W-1:0] load_val_i,
  output logic                       last_o
);
  typedef struct packed {
    logic [`EXP_CNT_W-1:0] count;
  } timer_state_t;

  timer_state_t cur;
  timer_state_t next_cur;

  // ==========================================================
  // down counter: loaded with n-1 so a phase lasts n clock periods
  always_comb begin
    next_cur = cur;
    if (load_i) begin
      next_cur.count = load_val_i;
    end else if (cur.count != '0) begin
      next_cur.count = cur.count - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign last_o = (cur.count == '0);
endmodule : phase_timer

/* File: hw/expansion_bus_phase_sequencer.sv */
`timescale 1ns/1ns
`include "exp_seq_defines.svh"
// ==========================================================
// access sequencer: one request, five timed phases (six in multiplexed mode), registered bus pins
module expansion_bus_phase_sequencer (
  input  wire logic                   clk_sys_i,
  input  wire logic                   rstn_i,
  // access request
  input  wire logic                   req_i,
  input  wire logic                   write_i,
  input  wire logic                   simplex_i,
  input  wire logic [`EXP_ADDR_W-1:0] addr_i,
  input  wire logic [`EXP_DATA_W-1:0] wdata_i,
  // phase settings, each field holds count minus one
  input  wire logic [`EXP_SHORT_W-1:0] address_phase_setting_i,
  input  wire logic [`EXP_SHORT_W-1:0] data_setup_phase_setting_i,
  input  wire logic [`EXP_LONG_W-1:0]  strobe_phase_setting_i,
  input  wire logic [`EXP_SHORT_W-1:0] hold_phase_setting_i,
  input  wire logic [`EXP_LONG_W-1:0]  recovery_phase_setting_i,
  // status and read data
  output logic                        busy_o,
  output logic                        done_o,
  output logic [`EXP_DATA_W-1:0]      rdata_o,
  // bus pins
  output logic                        address_latch_pulse_o,
  output logic                        chip_select_n_o,
  output logic                        write_strobe_n_o,
  output logic                        read_strobe_n_o,
  output logic [`EXP_ADDR_W-1:0]      addr_o,
  input  wire logic [`EXP_DATA_W-1:0] data_i,
  output logic [`EXP_DATA_W-1:0]      data_o,
  output logic                        data_oe_o
);
  // ==========================================================
  // all state in one packed record; next_cur is its combinational copy
  typedef struct packed {
    exp_seq_pkg::phase_t          phase;
    logic                         write;
    logic                         simplex;
    logic [`EXP_ADDR_W-1:0]       addr;
    logic [`EXP_DATA_W-1:0]       wdata;
    logic [`EXP_SHORT_W-1:0]      set_setup;
    logic [`EXP_LONG_W-1:0]       set_strobe;
    logic [`EXP_SHORT_W-1:0]      set_hold;
    logic [`EXP_LONG_W-1:0]       set_recov;
    logic                         busy;
    logic                         done;
    logic [`EXP_DATA_W-1:0]       rdata;
    logic                         ale;
    logic                         cs_n;
    logic                         wr_n;
    logic                         rd_n;
    logic [`EXP_ADDR_W-1:0]       addr_pins;
    logic [`EXP_DATA_W-1:0]       data_pins;
    logic                         data_oe;
  } seq_state_t;

  seq_state_t            cur;
  seq_state_t            next_cur;
  // timer load takes count minus one, last marks the final cycle of a phase
  logic                  tmr_load;
  logic [`EXP_CNT_W-1:0] tmr_val;
  logic                  tmr_last;

  // one shared timer: every phase is a count of bus clock periods
  phase_timer u_timer (
    .clk_sys_i  (clk_sys_i),
    .rstn_i     (rstn_i),
    .load_i     (tmr_load),
    .load_val_i (tmr_val),
    .last_o     (tmr_last)
  );

  // ==========================================================
  // phase sequencing; settings are captured at request time so a
  // change mid-access cannot stretch or cut a running phase
  always_comb begin
    logic in_cycle;
    in_cycle = 1'b0;
    next_cur = cur;
    next_cur.done = 1'b0;
    // timer is loaded only on a phase change and runs down on its own otherwise
    tmr_load = 1'b0;
    tmr_val  = '0;
    // requests are looked at only in idle; while busy they are ignored
    case (cur.phase)
      exp_seq_pkg::ST_IDLE: begin
        // capture the whole request so later input changes cannot disturb it
        if (req_i) begin
          next_cur.write      = write_i;
          next_cur.simplex    = simplex_i;
          next_cur.addr       = addr_i;
          next_cur.wdata      = wdata_i;
          next_cur.set_setup  = data_setup_phase_setting_i;
          next_cur.set_strobe = strobe_phase_setting_i;
          next_cur.set_hold   = hold_phase_setting_i;
          next_cur.set_recov  = recovery_phase_setting_i;
          tmr_load = 1'b1;
          tmr_val  = {2'b00, address_phase_setting_i};
          if (simplex_i) begin
            next_cur.phase = exp_seq_pkg::ST_ADDR;
          end else begin
            next_cur.phase = exp_seq_pkg::ST_LATCH;
          end
        end
      end
      exp_seq_pkg::ST_LATCH: begin
        // latch pulse stands for the address phase count
        if (tmr_last) begin
          tmr_load = 1'b1;
          tmr_val  = `EXP_LATCH_HOLD;
          next_cur.phase = exp_seq_pkg::ST_LHOLD;
        end
      end
      exp_seq_pkg::ST_LHOLD, exp_seq_pkg::ST_ADDR: begin
        // one address hold cycle after the pulse, or the simplex address lead
        if (tmr_last) begin
          tmr_load = 1'b1;
          tmr_val  = {2'b00, cur.set_setup};
          next_cur.phase = exp_seq_pkg::ST_SETUP;
        end
      end
      exp_seq_pkg::ST_SETUP: begin
        // select and write data lead the strobe by the setup count
        if (tmr_last) begin
          tmr_load = 1'b1;
          tmr_val  = cur.set_strobe;
          next_cur.phase = exp_seq_pkg::ST_STROBE;
        end
      end
      exp_seq_pkg::ST_STROBE: begin
        // strobe low for the strobe count, reads and writes alike
        if (tmr_last) begin
          tmr_load = 1'b1;
          tmr_val  = {2'b00, cur.set_hold};
          next_cur.phase = exp_seq_pkg::ST_HOLD;
          // sample on the last strobe cycle, data has had the full strobe to settle
          if (!cur.write) begin
            next_cur.rdata = data_i;
          end
        end
      end
      exp_seq_pkg::ST_HOLD: begin
        // select, address and write data held; done marks the end of the transfer
        if (tmr_last) begin
          tmr_load = 1'b1;
          tmr_val  = cur.set_recov;
          next_cur.phase = exp_seq_pkg::ST_RECOV;
          next_cur.done  = 1'b1;
        end
      end
      exp_seq_pkg::ST_RECOV: begin
        // bus quiet for the recovery count before the next request is taken
        if (tmr_last) begin
          next_cur.phase = exp_seq_pkg::ST_IDLE;
        end
      end
      default: begin
        // a broken state code returns to idle rather than locking the bus
        next_cur.phase = exp_seq_pkg::ST_IDLE;
      end
    endcase

    // pin values follow the next phase so every pin comes from a flop
    in_cycle = (next_cur.phase == exp_seq_pkg::ST_SETUP) ||
               (next_cur.phase == exp_seq_pkg::ST_STROBE) ||
               (next_cur.phase == exp_seq_pkg::ST_HOLD);
    // busy covers every phase from the taking edge to the end of recovery
    next_cur.busy = (next_cur.phase != exp_seq_pkg::ST_IDLE);
    next_cur.ale  = (next_cur.phase == exp_seq_pkg::ST_LATCH);
    // chip select spans setup, strobe and hold
    next_cur.cs_n = !in_cycle;
    // strobes fall only in the strobe phase
    next_cur.wr_n = !((next_cur.phase == exp_seq_pkg::ST_STROBE) && next_cur.write);
    next_cur.rd_n = !((next_cur.phase == exp_seq_pkg::ST_STROBE) && !next_cur.write);
    if (next_cur.simplex) begin
      // simplex: address on its own lines from address phase to end of hold
      next_cur.addr_pins = (in_cycle || next_cur.phase == exp_seq_pkg::ST_ADDR) ? next_cur.addr : '0;
      // write data lines are driven only from setup to the end of hold
      next_cur.data_pins = next_cur.wdata;
      next_cur.data_oe   = in_cycle && next_cur.write;
    end else begin
      // multiplexed: address on shared lines through latch and one hold cycle
      next_cur.addr_pins = '0;
      // write data replaces the address once the hold cycle is over
      if ((next_cur.phase == exp_seq_pkg::ST_LATCH) || (next_cur.phase == exp_seq_pkg::ST_LHOLD)) begin
        next_cur.data_pins = next_cur.addr;
        next_cur.data_oe   = 1'b1;
      end else begin
        next_cur.data_pins = next_cur.wdata;
        next_cur.data_oe   = in_cycle && next_cur.write;
      end
    end
  end

  // ==========================================================
  // state register; idle pins are inactive, strobes high
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      // select and strobes idle high so the bus sees no access during reset
      cur       <= '0;
      cur.phase <= exp_seq_pkg::ST_IDLE;
      cur.cs_n  <= 1'b1;
      cur.wr_n  <= 1'b1;
      cur.rd_n  <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  // ==========================================================
  // outputs are plain copies of state flops, no logic after the register
  assign busy_o                = cur.busy;
  assign done_o                = cur.done;
  assign rdata_o               = cur.rdata;
  assign address_latch_pulse_o = cur.ale;
  assign chip_select_n_o       = cur.cs_n;
  assign write_strobe_n_o      = cur.wr_n;
  assign read_strobe_n_o       = cur.rd_n;
  assign addr_o                = cur.addr_pins;
  assign data_o                = cur.data_pins;
  assign data_oe_o             = cur.data_oe;
endmodule : expansion_bus_phase_sequencer

/* File: tb/exp_seq_monitor.sv */
`timescale 1ns/1ns
`include "exp_seq_defines.svh"
// ====================
// pin-level checker for the sequencer
module exp_seq_monitor (
  input wire logic                   clk_sys_i,
  input wire logic                   rstn_i,
  input wire logic                   simplex_i,
  input wire logic                   busy_o,
  input wire logic                   done_o,
  input wire logic                   address_latch_pulse_o,
  input wire logic                   chip_select_n_o,
  input wire logic                   write_strobe_n_o,
  input wire logic                   read_strobe_n_o,
  input wire logic                   data_oe_o,
  input wire logic [`EXP_ADDR_W-1:0] addr_o
);
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);
  // latch and select ordering
  chk_latch_width: assert property ($rose(address_latch_pulse_o) |-> ##[1:4] !address_latch_pulse_o)
    else $error("latch pulse too long");
  chk_latch_drives_addr: assert property (address_latch_pulse_o |-> data_oe_o && chip_select_n_o)
    else $error("no address on shared lines at latch");
  chk_select_after_latch: assert property ($fell(address_latch_pulse_o) |-> chip_select_n_o ##1 !chip_select_n_o)
    else $error("select not one cycle after latch");
  chk_latch_mux_only: assert property (address_latch_pulse_o |-> addr_o == '0)
    else $error("latch pulse with simplex address");
  chk_latch_mode_match: assert property ($rose(busy_o) |-> address_latch_pulse_o == !$past(simplex_i))
    else $error("latch pulse does not match the bus mode");
  // strobe, setup, hold and recovery framing
  chk_strobe_in_select: assert property (!write_strobe_n_o || !read_strobe_n_o |-> !chip_select_n_o)
    else $error("strobe outside select");
  chk_write_data_on: assert property (!write_strobe_n_o |-> data_oe_o && read_strobe_n_o)
    else $error("write data missing in strobe");
  chk_write_setup: assert property ($fell(write_strobe_n_o) |-> $past(data_oe_o) && !$past(chip_select_n_o))
    else $error("no data setup before strobe");
  chk_write_hold: assert property ($rose(write_strobe_n_o) |-> data_oe_o && !chip_select_n_o)
    else $error("data dropped after strobe");
  chk_done_recovery: assert property (done_o |-> busy_o && chip_select_n_o && !data_oe_o ##1 !done_o)
    else $error("bad recovery start");
endmodule : exp_seq_monitor

bind expansion_bus_phase_sequencer exp_seq_monitor i_exp_seq_monitor (
  .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .simplex_i(simplex_i), .busy_o(busy_o), .done_o(done_o),
  .address_latch_pulse_o(address_latch_pulse_o), .chip_select_n_o(chip_select_n_o),
  .write_strobe_n_o(write_strobe_n_o), .read_strobe_n_o(read_strobe_n_o),
  .data_oe_o(data_oe_o), .addr_o(addr_o));

/* File: tb/exp_periph_model.sv */
`timescale 1ns/1ns
// ====================
// peripheral: external address latch, read answer, write capture
module exp_periph_model (
  input  wire logic        clk_sys_i,
  input  wire logic        ale_i,
  input  wire logic        cs_n_i,
  input  wire logic        wr_n_i,
  input  wire logic        rd_n_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] data_i,
  output logic      [15:0] read_data_o,
  output logic      [15:0] wr_seen_o
);
  logic [15:0] lat;
  logic [15:0] last = 16'h0000;
  // outside a read the lines toggle so a stale value never looks valid
  assign read_data_o = (!cs_n_i && !rd_n_i) ? ((addr_i != '0 ? addr_i : lat) ^ 16'h5a5a) : ~last;
  // latch address while pulse high, record write data during strobe
  always @(posedge clk_sys_i) begin
    if (ale_i) lat <= data_i;
    if (!wr_n_i) wr_seen_o <= data_i;
    last <= read_data_o;
  end
endmodule : exp_periph_model

/* File: tb/tb.sv */
`timescale 1ns/1ns
`include "exp_seq_defines.svh"
// ====================
// bench top
module tb;
  logic clk_sys_i = 0, rstn_i = 0, req_i = 0, write_i = 0, simplex_i = 0;
  logic [1:0]  a_set = 0, s_set = 0, h_set = 0;
  logic [3:0]  t_set = 0, r_set = 0;
  logic [15:0] addr_i = 0, wdata_i = 0, data_i, data_o, rdata_o, addr_o, wr_seen;
  logic        busy_o, done_o, ale, cs_n, wr_n, rd_n, oe;
  int          n_fail = 0;
  int          checked = 0;
  expansion_bus_phase_sequencer i_expansion_bus_phase_sequencer (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .req_i(req_i), .write_i(write_i), .simplex_i(simplex_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .address_phase_setting_i(a_set), .data_setup_phase_setting_i(s_set),
    .strobe_phase_setting_i(t_set), .hold_phase_setting_i(h_set), .recovery_phase_setting_i(r_set),
    .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o), .address_latch_pulse_o(ale),
    .chip_select_n_o(cs_n), .write_strobe_n_o(wr_n), .read_strobe_n_o(rd_n), .addr_o(addr_o),
    .data_i(data_i), .data_o(data_o), .data_oe_o(oe));
  exp_periph_model i_exp_periph_model (.clk_sys_i(clk_sys_i), .ale_i(ale), .cs_n_i(cs_n), .wr_n_i(wr_n),
    .rd_n_i(rd_n), .addr_i(addr_o), .data_i(data_o), .read_data_o(data_i), .wr_seen_o(wr_seen));
  // 20 MHz clock
  initial begin
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one access; phases are measured from the pins, not from internal state
  task automatic access(input logic w, input logic smp, input logic [3:0] a, s, t, h, r, input logic [15:0] ad, wd);
    int n[5];
    int ph;
    int na;
    n = '{default: 0};
    ph = 0;
    na = 0;
    @(posedge clk_sys_i);
    {req_i, write_i, simplex_i, addr_i, wdata_i} <= {1'b1, w, smp, ad, wd};
    {a_set, s_set, t_set, h_set, r_set} <= {a[1:0], s[1:0], t, h[1:0], r};
    @(posedge clk_sys_i);
    req_i <= 1'b0;
    for (int k = 0; k < 100; k++) begin
      #1;
      if (ph == 0 && !cs_n) ph = 1;
      if (ph == 1 && !(wr_n && rd_n)) ph = 2;
      if (ph == 2 && wr_n && rd_n) ph = 3;
      if (ph == 3 && cs_n) ph = 4;
      if (ph == 4 && !busy_o) break;
      n[ph]++;
      na += int'(ale);
      if (ale && na == 1) chk(data_o, ad);
      if (ph == 0 && !smp && !ale) chk(data_o, ad);
      if (smp && ph < 4) chk(addr_o, ad);
      if (w && ph >= 1 && ph <= 3) chk(data_o, wd);
      if (ph > 0) chk(16'(oe), 16'(w && ph < 4));
      if (ph == 4) chk(16'(done_o), 16'(n[4] == 1));
      if (done_o && !w) chk(rdata_o, ad ^ 16'h5a5a);
      @(posedge clk_sys_i);
    end
    chk(16'(busy_o), 16'h0000);
    chk(16'(na), smp ? 16'h0000 : 16'(a + 1));
    chk(16'(n[0]), 16'(a + (smp ? 1 : 2)));
    chk(16'(n[1]), 16'(s + 1));
    chk(16'(n[2]), 16'(t + 1));
    chk(16'(n[3]), 16'(h + 1));
    chk(16'(n[4]), 16'(r + 1));
    if (w) chk(wr_seen, wd);
  endtask : access
  task automatic t_walk;
    access(1, 0, 0, 0, 0, 0, 0, 16'ha1c3, 16'h3c5a);
    access(0, 0, 0, 0, 0, 0, 0, 16'h1234, 16'h0000);
    $display("test walk done");
  endtask : t_walk
  // every setting value, both modes, both directions, back to back
  task automatic t_sweep;
    for (logic [4:0] i = 0; i < 16; i++) begin
      access(i[0], i[1], i[3:2], i[1:0], i[3:0], 4'(3 - i[1:0]), 4'(15 - i), {i[3:0], 12'h0f1}, {4'h9, i[3:0], 8'h6e});
    end
    $display("test sweep done");
  endtask : t_sweep
  task automatic finish_test;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  // main sequence
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    t_walk();
    t_sweep();
    finish_test();
  end
  // watchdog, well past the longest expected run
  initial begin
    #(3000 * 50);
    n_fail++;
    finish_test();
  end
endmodule : tb
